// File: hdl/tca_cfg_regs.sv
// Purpose: Address configuration bank with adoption and byte emission
// Assumes: One-cycle register port, read data valid with ack
// Notes:   Illegal family codes emit nothing for family-dependent lengths
`timescale 1ns/1ns
module tca_cfg_regs
  import tcacfg_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire tca_bus_req_s bus_i,
  output logic              ack_o,
  output logic [31:0]       rdata_o,
  input  wire logic         emit_start_i,
  input  wire logic [1:0]   emit_sel_i,
  output logic              emit_busy_o,
  output logic              byte_valid_o,
  output logic              byte_last_o,
  output logic [7:0]        byte_o,
  output tca_addr_s         addr_o
);

  tca_state_s st_r;
  tca_state_s st_nxt;
  logic       ack_r;
  logic       wr;
  logic       is_v6;
  logic [4:0] len;
  logic [127:0] src;

  assign wr    = bus_i.req && bus_i.we;
  assign is_v6 = (st_r.fam == FAM_IPV6);

  // Length and source of an emission request
  always_comb begin
    len = 5'h00;
    src = '0;
    case (emit_sel_i)
      SEL_CLIENT: begin
        len = is_v6 ? LEN_CLIENT6 : 5'h00;
        src = {32'h0, st_r.act.client6};
      end
      SEL_SRV_HW: begin
        len = LEN_HW;
        src = {80'h0, st_r.act.srv_hw};
      end
      SEL_SRV_NET: begin
        len = is_v6 ? LEN_NET6 : ((st_r.fam == FAM_IPV4) ? LEN_NET4 : 5'h00);
        src = st_r.act.srv_net;
      end
      default: begin
        len = is_v6 ? LEN_MASK6 : ((st_r.fam == FAM_IPV4) ? LEN_NET4 : 5'h00);
        src = {64'h0, st_r.act.mask};
      end
    endcase
  end

  // Next state: register writes, adoption, emission, read mux
  always_comb begin
    st_nxt = st_r;
    st_nxt.act.ipv6 = is_v6;
    // Flags clear once adopted; a fresh write in the same cycle wins
    st_nxt.vld = '0;
    if (st_r.vld[VLD_CLIENT]) begin
      st_nxt.act.client6 = is_v6 ? {st_r.cli6[2], st_r.cli6[1], st_r.cli6[0]} : 96'h0;
    end
    if (st_r.vld[VLD_SRV_HW]) begin
      st_nxt.act.srv_hw = {st_r.shw[1][15:0], st_r.shw[0]};
    end
    if (st_r.vld[VLD_SRV_NET]) begin
      // Word 0 holds bytes 0-3, so it is the whole IPv4 address
      st_nxt.act.srv_net = is_v6 ? {st_r.snet[3], st_r.snet[2], st_r.snet[1], st_r.snet[0]}
                                 : {96'h0, st_r.snet[0]};
    end
    if (st_r.vld[VLD_MASK]) begin
      st_nxt.act.mask = is_v6 ? {st_r.mask[1], st_r.mask[0]} : {32'h0, st_r.mask[0]};
    end
    // Register writes; byte k of a word lands in bits 8k+7:8k
    if (wr && bus_i.addr == OFS_CTRL) begin
      st_nxt.vld = bus_i.wdata[VLD_HI:VLD_LO];
    end else if (wr && bus_i.addr == OFS_MODE) begin
      st_nxt.fam = bus_i.wdata[1:0];
    end else if (wr && bus_i.addr == OFS_CLIENT_IPV6_1) begin
      st_nxt.cli6[0] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_CLIENT_IPV6_2) begin
      st_nxt.cli6[1] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_CLIENT_IPV6_3) begin
      st_nxt.cli6[2] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_SRV_HW_LOW) begin
      st_nxt.shw[0] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_SRV_HW_HIGH) begin
      st_nxt.shw[1] = {16'h0, bus_i.wdata[15:0]};
    end else if (wr && bus_i.addr == OFS_SRV_NET_0) begin
      st_nxt.snet[0] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_SRV_IPV6_1) begin
      st_nxt.snet[1] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_SRV_IPV6_2) begin
      st_nxt.snet[2] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_SRV_IPV6_3) begin
      st_nxt.snet[3] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_NETMASK_0) begin
      st_nxt.mask[0] = bus_i.wdata;
    end else if (wr && bus_i.addr == OFS_NETMASK_1) begin
      st_nxt.mask[1] = bus_i.wdata;
    end
    // Read mux; unmapped addresses read zero
    st_nxt.rdata = REG_RESET;
    if (bus_i.addr == OFS_CTRL) begin
      st_nxt.rdata[VLD_HI:VLD_LO] = st_r.vld;
    end else if (bus_i.addr == OFS_MODE) begin
      st_nxt.rdata[1:0] = st_r.fam;
    end else if (bus_i.addr == OFS_CLIENT_IPV6_1) begin
      st_nxt.rdata = st_r.cli6[0];
    end else if (bus_i.addr == OFS_CLIENT_IPV6_2) begin
      st_nxt.rdata = st_r.cli6[1];
    end else if (bus_i.addr == OFS_CLIENT_IPV6_3) begin
      st_nxt.rdata = st_r.cli6[2];
    end else if (bus_i.addr == OFS_SRV_HW_LOW) begin
      st_nxt.rdata = st_r.shw[0];
    end else if (bus_i.addr == OFS_SRV_HW_HIGH) begin
      st_nxt.rdata = {16'h0, st_r.shw[1][15:0]};
    end else if (bus_i.addr == OFS_SRV_NET_0) begin
      st_nxt.rdata = st_r.snet[0];
    end else if (bus_i.addr == OFS_SRV_IPV6_1) begin
      st_nxt.rdata = st_r.snet[1];
    end else if (bus_i.addr == OFS_SRV_IPV6_2) begin
      st_nxt.rdata = st_r.snet[2];
    end else if (bus_i.addr == OFS_SRV_IPV6_3) begin
      st_nxt.rdata = st_r.snet[3];
    end else if (bus_i.addr == OFS_NETMASK_0) begin
      st_nxt.rdata = st_r.mask[0];
    end else if (bus_i.addr == OFS_NETMASK_1) begin
      st_nxt.rdata = st_r.mask[1];
    end
    if (!(bus_i.req && !bus_i.we)) begin
      st_nxt.rdata = st_r.rdata; // Hold last read data
    end
    // Emission shifts right so byte 0 goes first
    case (st_r.st)
      TCA_IDLE: begin
        if (emit_start_i && len != 5'h00) begin
          st_nxt.sh  = src;
          st_nxt.cnt = len;
          st_nxt.st  = TCA_SHIFT;
        end
      end
      TCA_SHIFT: begin
        st_nxt.sh  = {8'h00, st_r.sh[127:8]};
        st_nxt.cnt = st_r.cnt - 5'h01;
        if (st_r.cnt == 5'h01) begin
          st_nxt.st = TCA_IDLE;
        end
      end
      default: st_nxt.st = TCA_IDLE;
    endcase
  end

  // State register; all configuration resets to zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= '0;
      st_r.st  <= TCA_IDLE;
      ack_r    <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      ack_r <= bus_i.req;
    end
  end

  assign ack_o        = ack_r;
  assign rdata_o      = st_r.rdata;
  assign addr_o       = st_r.act;
  assign emit_busy_o  = (st_r.st == TCA_SHIFT);
  assign byte_valid_o = (st_r.st == TCA_SHIFT);
  assign byte_last_o  = (st_r.st == TCA_SHIFT) && (st_r.cnt == 5'h01);
  assign byte_o       = st_r.sh[7:0];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_hw_high_zero;
    bus_i.req && !bus_i.we && bus_i.addr == OFS_SRV_HW_HIGH |=> rdata_o[31:16] == 16'h0;
  endproperty
  a_hw_high_zero: assert property (p_hw_high_zero) else $error("hw high reserved not zero");

  property p_autoclear;
    st_r.vld[VLD_SRV_NET] && !(wr && bus_i.addr == OFS_CTRL) |=> !st_r.vld[VLD_SRV_NET];
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("valid flag not cleared");

  property p_hw_adopt;
    st_r.vld[VLD_SRV_HW] |=>
      addr_o.srv_hw == {$past(st_r.shw[1][15:0]), $past(st_r.shw[0])};
  endproperty
  a_hw_adopt: assert property (p_hw_adopt) else $error("hw address not adopted");

  property p_client_v4_ignored;
    st_r.vld[VLD_CLIENT] && !is_v6 |=> addr_o.client6 == 96'h0;
  endproperty
  a_client_v4_ignored: assert property (p_client_v4_ignored) else $error("client v6 used in v4");

  property p_net_v4_whole;
    st_r.vld[VLD_SRV_NET] && st_r.fam == FAM_IPV4 |=>
      addr_o.srv_net == {96'h0, $past(st_r.snet[0])};
  endproperty
  a_net_v4_whole: assert property (p_net_v4_whole) else $error("v4 server address wrong");

  property p_mask_v6;
    st_r.vld[VLD_MASK] && is_v6 |=> addr_o.mask[63:32] == $past(st_r.mask[1]);
  endproperty
  a_mask_v6: assert property (p_mask_v6) else $error("mask upper word not adopted");

  property p_first_byte;
    emit_start_i && !emit_busy_o && emit_sel_i == SEL_SRV_HW |=>
      byte_valid_o && byte_o == $past(st_r.act.srv_hw[7:0]) ##1 byte_o == $past(st_r.sh[15:8]);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("byte order wrong");

  property p_hw_len;
    emit_start_i && !emit_busy_o && emit_sel_i == SEL_SRV_HW |=>
      byte_valid_o [*6] ##1 !byte_valid_o;
  endproperty
  a_hw_len: assert property (p_hw_len) else $error("hw emission length wrong");

  property p_net_v4_len;
    emit_start_i && !emit_busy_o && emit_sel_i == SEL_SRV_NET && st_r.fam == FAM_IPV4 |=>
      byte_valid_o [*4] ##1 !byte_valid_o;
  endproperty
  a_net_v4_len: assert property (p_net_v4_len) else $error("v4 emission length wrong");

endmodule

// File: inc/tcacfg_pkg.sv
// Purpose: Constants and types for the time client address configuration bank
// Assumes: Single 50 MHz core clock, synchronous active-high reset
// Notes:   Offsets are byte addresses of 32-bit words
package tcacfg_pkg;

  localparam logic [7:0] OFS_CTRL          = 8'h80;
  localparam logic [7:0] OFS_MODE          = 8'h84;
  localparam logic [7:0] OFS_CLIENT_IPV6_1 = 8'h98;
  localparam logic [7:0] OFS_CLIENT_IPV6_2 = 8'h9C;
  localparam logic [7:0] OFS_CLIENT_IPV6_3 = 8'hA0;
  localparam logic [7:0] OFS_SRV_HW_LOW    = 8'hA4;
  localparam logic [7:0] OFS_SRV_HW_HIGH   = 8'hA8;
  localparam logic [7:0] OFS_SRV_NET_0     = 8'hAC;
  localparam logic [7:0] OFS_SRV_IPV6_1    = 8'hB0;
  localparam logic [7:0] OFS_SRV_IPV6_2    = 8'hB4;
  localparam logic [7:0] OFS_SRV_IPV6_3    = 8'hB8;
  localparam logic [7:0] OFS_NETMASK_0     = 8'hBC;
  localparam logic [7:0] OFS_NETMASK_1     = 8'hC0;

  // Valid flag positions in the control word
  localparam int VLD_CLIENT  = 3;
  localparam int VLD_SRV_HW  = 4;
  localparam int VLD_SRV_NET = 5;
  localparam int VLD_MASK    = 6;
  localparam int VLD_LO      = 3;
  localparam int VLD_HI      = 6;

  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [1:0]  FAM_IPV4   = 2'h1;
  localparam logic [1:0]  FAM_IPV6   = 2'h2;

  // Emission selects and byte counts
  localparam logic [1:0] SEL_CLIENT  = 2'h0;
  localparam logic [1:0] SEL_SRV_HW  = 2'h1;
  localparam logic [1:0] SEL_SRV_NET = 2'h2;
  localparam logic [1:0] SEL_MASK    = 2'h3;
  localparam logic [4:0] LEN_CLIENT6 = 5'h0C;
  localparam logic [4:0] LEN_HW      = 5'h06;
  localparam logic [4:0] LEN_NET4    = 5'h04;
  localparam logic [4:0] LEN_NET6    = 5'h10;
  localparam logic [4:0] LEN_MASK6   = 5'h08;

  typedef enum logic [1:0] {
    TCA_IDLE  = 2'b01,
    TCA_SHIFT = 2'b10
  } tca_emit_e;

  // Register port request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tca_bus_req_s;

  // Adopted addresses, byte 0 in bits 7:0
  typedef struct packed {
    logic [95:0]  client6;
    logic [47:0]  srv_hw;
    logic [127:0] srv_net;
    logic [63:0]  mask;
    logic         ipv6;
  } tca_addr_s;

  typedef struct packed {
    logic [2:0][31:0] cli6;
    logic [1:0][31:0] shw;
    logic [3:0][31:0] snet;
    logic [1:0][31:0] mask;
    logic [1:0]       fam;
    logic [VLD_HI:VLD_LO] vld;
    tca_addr_s        act;
    logic [127:0]     sh;
    logic [4:0]       cnt;
    tca_emit_e        st;
    logic [31:0]      rdata;
  } tca_state_s;

endpackage

// File: testbench/tca_cfg_regs_tb_top.sv
// Purpose: Self-checking bench for the address configuration bank
// Assumes: Register port answers one cycle after each request
// Notes:   Family switch, adoption and byte emission checked per mode
`timescale 1ns/1ns
module tca_cfg_regs_tb_top
  import tcacfg_pkg::*;
;
  logic         clk_i;
  logic         srst_i;
  tca_bus_req_s bus_i;
  logic         ack_o;
  logic [31:0]  rdata_o;
  logic         emit_start_i;
  logic [1:0]   emit_sel_i;
  logic         emit_busy_o;
  logic         byte_valid_o;
  logic         byte_last_o;
  logic [7:0]   byte_o;
  tca_addr_s    addr_o;
  int           failures;
  int           check_count;
  logic [31:0]  rd;
  // Word table in offset order; index 4 is the half-reserved word
  logic [7:0]   ofs_t [11] = '{OFS_CLIENT_IPV6_1, OFS_CLIENT_IPV6_2, OFS_CLIENT_IPV6_3,
    OFS_SRV_HW_LOW, OFS_SRV_HW_HIGH, OFS_SRV_NET_0, OFS_SRV_IPV6_1, OFS_SRV_IPV6_2,
    OFS_SRV_IPV6_3, OFS_NETMASK_0, OFS_NETMASK_1};
  logic [31:0]  val_t [11] = '{32'h07060504, 32'h0B0A0908, 32'h0F0E0D0C, 32'h01234567,
    32'hDEAD89AB, 32'hC0A80A01, 32'h27262524, 32'h2B2A2928, 32'h2F2E2D2C,
    32'hFFFFFF00, 32'hFFFF0000};

  tca_cfg_regs uut (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .bus_i        (bus_i),
    .ack_o        (ack_o),
    .rdata_o      (rdata_o),
    .emit_start_i (emit_start_i),
    .emit_sel_i   (emit_sel_i),
    .emit_busy_o  (emit_busy_o),
    .byte_valid_o (byte_valid_o),
    .byte_last_o  (byte_last_o),
    .byte_o       (byte_o),
    .addr_o       (addr_o)
  );

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One request, held over its taking edge; a missing ack ends the run
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    bus_i <= '{req: 1'b1, we: we, addr: a, wdata: d};
    @(posedge clk_i);
    bus_i.req <= 1'b0;
    #1;
    for (i = 0; i < 4 && ack_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (ack_o !== 1'b1) begin
      failures++;
      end_of_test();
    end
    rd = rdata_o;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Start pulse, then one byte per cycle; nothing expected when n is zero
  task automatic emit(input logic [1:0] sel, input int n, input logic [127:0] exp);
    int k;
    @(posedge clk_i);
    emit_start_i <= 1'b1;
    emit_sel_i   <= sel;
    @(posedge clk_i);
    emit_start_i <= 1'b0;
    #1;
    for (k = 0; k < n; k++) begin
      chk({byte_valid_o, byte_last_o, byte_o}, {1'b1, k == n - 1, exp[8*k+:8]});
      chk(emit_busy_o, 1'b1);
      @(posedge clk_i);
      #1;
    end
    chk(byte_valid_o, 1'b0);
    chk(emit_busy_o, 1'b0);
  endtask

  // Select a family, raise all four valid flags, then check adoption and output
  task automatic adopt(input logic [1:0] fam, input logic v6);
    logic [127:0] sn;
    logic [63:0]  mk;
    sn = v6 ? {val_t[8], val_t[7], val_t[6], val_t[5]} : {96'h0, val_t[5]};
    mk = v6 ? {val_t[10], val_t[9]} : {32'h0, val_t[9]};
    acc(1'b1, OFS_MODE, {30'h0, fam});
    rd_chk(OFS_MODE, {30'h0, fam});
    // Every word is already written, so the flags adopt complete values
    acc(1'b1, OFS_CTRL, 32'h00000078);
    rd_chk(OFS_CTRL, 32'h0);
    chk(addr_o.ipv6, v6);
    chk(addr_o.client6, v6 ? {val_t[2], val_t[1], val_t[0]} : 96'h0);
    chk(addr_o.srv_hw, {16'h89AB, val_t[3]});
    chk(addr_o.srv_net, fam[0] ^ fam[1] ? sn : {96'h0, val_t[5]});
    chk(addr_o.mask, fam[0] ^ fam[1] ? mk : {32'h0, val_t[9]});
    emit(SEL_SRV_HW, 6, {16'h89AB, val_t[3]});
    emit(SEL_CLIENT, v6 ? 12 : 0, {val_t[2], val_t[1], val_t[0]});
    emit(SEL_SRV_NET, fam[0] ^ fam[1] ? (v6 ? 16 : 4) : 0, sn);
    emit(SEL_MASK, fam[0] ^ fam[1] ? (v6 ? 8 : 4) : 0, mk);
  endtask

  // Reset values, an unmapped place, nothing emitted with family zero
  task automatic t_reset;
    for (int k = 0; k < 11; k++) rd_chk(ofs_t[k], 32'h0);
    rd_chk(8'hFC, 32'h0);
    emit(SEL_SRV_NET, 0, 128'h0);
  endtask

  // All words written one request every other cycle, then read; upper half of 0xA8 stays zero
  task automatic t_regs;
    for (int k = 0; k < 11; k++) acc(1'b1, ofs_t[k], val_t[k]);
    for (int k = 0; k < 11; k++) rd_chk(ofs_t[k], k == 4 ? 32'h000089AB : val_t[k]);
  endtask

  // Mid-run reset must drop every word and every adopted address
  task automatic t_midreset;
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk(|addr_o, 1'b0);
    t_reset();
  endtask

  // Main sequence: IPv4, IPv6, an illegal family code, then a reset
  initial begin
    failures     = 0;
    check_count  = 0;
    srst_i       = 1'b1;
    bus_i        = '0;
    emit_start_i = 1'b0;
    emit_sel_i   = 2'h0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_regs();
    adopt(FAM_IPV4, 1'b0);
    adopt(FAM_IPV6, 1'b1);
    adopt(2'h3, 1'b0);
    t_midreset();
    end_of_test();
  end
endmodule
